// [hw/asag_top.sv]
// Alarm status aggregator: five sticky alarms, mask, summary and status pin.
// Assumes all condition inputs and the register port are in the clock domain.
//
// Notes on behaviour
// - Lock-lost flag, bit 4, held set while PLL unlocked.
// - Link flag, bit 3, set when link enabled but not encoding data.
// - Realign flag, bit 2, set when SYSREF realigns internal clocks.
// - Phase upset flag, bit 1: link disabled, NCO sync, or accumulator mismatch.
// - Divider flag, bit 0, set while channel dividers disagree.
// - Flags are sticky; writing one clears, writing zero keeps.
// - Mask bit one removes that flag from the summary.
// - Mask register resets to 0x1F.
// - Bits 7 to 5 of status and mask are plain storage, reset zero.
// - Summary reads one when any unmasked flag is set.
// - Status pin carries summary when the select chooses it.
// - Status register resets to 0x1F.
`timescale 1ns/10ps
`include "asag_defs.svh"
module asag_top
  import asag_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Register port
  input wire logic [11:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  // Alarm conditions
  input wire logic pll_locked,
  input wire logic link_enable,
  input wire logic data_encoding_state,
  input wire logic sysref_realign,
  input wire logic nco_sync,
  input wire logic nco_phase_mismatch,
  input wire logic divider_mismatch,
  // Calibration status from the calibration engine
  input wire logic cal_status,
  // Status pin and interrupt
  output logic status_output_pin,
  output logic alarm_irq
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [11:0] a, input logic [11:0] b);
    hit = (a == b);
  endfunction

  asag_if fl ();

  // ----------------------------------------------------------------
  // Alarm events
  // ----------------------------------------------------------------
  logic link_enable_reg;
  logic link_enable_next;

  always_comb begin
    link_enable_next = link_enable;
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      link_enable_reg <= 1'b0;
    end else begin
      link_enable_reg <= link_enable_next;
    end
  end

  always_comb begin
    fl.events[`ASAG_BIT_LOCK_LOST] = ~pll_locked;
    fl.events[`ASAG_BIT_LINK] = link_enable & ~data_encoding_state;
    fl.events[`ASAG_BIT_REALIGN] = sysref_realign;
    // Disable, sync or mismatch; disable seen as a falling enable
    fl.events[`ASAG_BIT_PHASE] = (link_enable_reg & ~link_enable) | nco_sync | nco_phase_mismatch;
    fl.events[`ASAG_BIT_DIVIDER] = divider_mismatch;
  end

  asag_flag_engine u_engine (
    .clock(clock),
    .reset_n(reset_n),
    .fl(fl.engine)
  );

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  asag_flags_type mask_reg;
  asag_flags_type mask_next;
  logic [2:0] mask_rsvd_reg;
  logic [2:0] mask_rsvd_next;
  logic [2:0] status_rsvd_reg;
  logic [2:0] status_rsvd_next;
  asag_pin_sel_type pin_sel_reg;
  asag_pin_sel_type pin_sel_next;
  asag_byte_type rdata_reg;
  asag_byte_type rdata_next;
  logic summary;

  assign summary = |(fl.flags & ~mask_reg);

  always_comb begin
    mask_next = mask_reg;
    mask_rsvd_next = mask_rsvd_reg;
    status_rsvd_next = status_rsvd_reg;
    pin_sel_next = pin_sel_reg;
    fl.clear_ones = '0;
    if (reg_write) begin
      if (hit(reg_addr, `ASAG_ADDR_STATUS)) begin
        fl.clear_ones = reg_wdata[`ASAG_FLAG_MSB:0];
        status_rsvd_next = reg_wdata[7:5];
      end
      if (hit(reg_addr, `ASAG_ADDR_MASK)) begin
        mask_next = reg_wdata[`ASAG_FLAG_MSB:0];
        mask_rsvd_next = reg_wdata[7:5];
      end
      if (hit(reg_addr, `ASAG_ADDR_CAL_SEL)) begin
        pin_sel_next = reg_wdata[0] ? ASAG_PIN_ALARM : ASAG_PIN_CAL;
      end
    end
    rdata_next = 8'h00;
    if (reg_read) begin
      case (reg_addr)
        `ASAG_ADDR_SUMMARY: rdata_next = {7'h00, summary};
        `ASAG_ADDR_STATUS: rdata_next = {status_rsvd_reg, fl.flags};
        `ASAG_ADDR_MASK: rdata_next = {mask_rsvd_reg, mask_reg};
        `ASAG_ADDR_CAL_SEL: rdata_next = {7'h00, (pin_sel_reg == ASAG_PIN_ALARM)};
        default: rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      mask_reg <= asag_flags_type'(`ASAG_MASK_RESET);
      mask_rsvd_reg <= `ASAG_RSVD_RESET;
      status_rsvd_reg <= `ASAG_RSVD_RESET;
      pin_sel_reg <= ASAG_PIN_CAL;
      rdata_reg <= 8'h00;
    end else begin
      mask_reg <= mask_next;
      mask_rsvd_reg <= mask_rsvd_next;
      status_rsvd_reg <= status_rsvd_next;
      pin_sel_reg <= pin_sel_next;
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;

  // ----------------------------------------------------------------
  // Pin and interrupt
  // ----------------------------------------------------------------
  logic pin_reg;
  logic pin_next;

  always_comb begin
    case (pin_sel_reg)
      ASAG_PIN_ALARM: pin_next = summary;
      ASAG_PIN_CAL: pin_next = cal_status;
      default: pin_next = cal_status;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      pin_reg <= 1'b0;
    end else begin
      pin_reg <= pin_next;
    end
  end

  assign status_output_pin = pin_reg;
  // Level interrupt is the live summary, so it drops as soon as a clear lands
  assign alarm_irq = summary;
endmodule

// [hw/asag_defs.svh]
// Offsets, field positions, reset values of the alarm status aggregator.
// Assumes a register port with 12-bit word addresses.
`ifndef ASAG_DEFS_SVH
`define ASAG_DEFS_SVH

`define ASAG_ADDR_SUMMARY 12'h2c0
`define ASAG_ADDR_STATUS 12'h2c1
`define ASAG_ADDR_MASK 12'h2c2
`define ASAG_ADDR_CAL_SEL 12'h2c3

`define ASAG_BIT_LOCK_LOST 4
`define ASAG_BIT_LINK 3
`define ASAG_BIT_REALIGN 2
`define ASAG_BIT_PHASE 1
`define ASAG_BIT_DIVIDER 0
`define ASAG_FLAG_MSB 4

`define ASAG_STATUS_RESET 8'h1f
`define ASAG_MASK_RESET 8'h1f
`define ASAG_RSVD_RESET 3'h0
`define ASAG_CAL_SEL_RESET 8'h00

`endif

// [hw/asag_pkg.sv]
// Types of the alarm status aggregator.
// Assumes asag_defs.svh is compiled alongside.
package asag_pkg;
  typedef logic [7:0] asag_byte_type;
  typedef logic [4:0] asag_flags_type;
  typedef enum logic [1:0] {
    ASAG_PIN_CAL = 2'b00,
    ASAG_PIN_ALARM = 2'b01
  } asag_pin_sel_type;
endpackage

// [hw/asag_if.sv]
// Flag bundle between the register file and the flag engine.
// Assumes a single clock domain.
`timescale 1ns/10ps
interface asag_if;
  import asag_pkg::*;
  asag_flags_type events;
  asag_flags_type clear_ones;
  asag_flags_type flags;
  modport regs (output clear_ones, input flags);
  modport engine (input events, input clear_ones, output flags);
  modport source (output events);
endinterface

// [hw/asag_flag_engine.sv]
// Sticky write-one-to-clear alarm flags.
// Assumes events are synchronous levels in the clock domain.
`timescale 1ns/10ps
`include "asag_defs.svh"
module asag_flag_engine
  import asag_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Flag bundle
  asag_if.engine fl
);
  asag_flags_type flags_reg;
  asag_flags_type flags_next;

  always_comb begin
    flags_next = (flags_reg & ~fl.clear_ones) | fl.events;
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      flags_reg <= asag_flags_type'(`ASAG_STATUS_RESET);
    end else begin
      flags_reg <= flags_next;
    end
  end

  assign fl.flags = flags_reg;
endmodule

// [sim/asag_top_sva.sv]
// Port-level checker for the alarm status aggregator.
// Assumes asag_defs.svh is on the include path.
`timescale 1ns/10ps
`include "asag_defs.svh"
module asag_checker (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Register port
  input wire logic [11:0] reg_addr,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  // Conditions and outputs
  input wire logic pll_locked,
  input wire logic link_enable,
  input wire logic data_encoding_state,
  input wire logic sysref_realign,
  input wire logic nco_sync,
  input wire logic divider_mismatch,
  input wire logic cal_status,
  input wire logic status_output_pin,
  input wire logic alarm_irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  wire rd_st = reg_read && reg_addr == `ASAG_ADDR_STATUS;
  wire rd_sum = reg_read && reg_addr == `ASAG_ADDR_SUMMARY;
  property p_lock; !pll_locked ##1 rd_st |=> reg_rdata[4]; endproperty
  a_lock: assert property (p_lock) else $error("lock flag clear");
  property p_link; link_enable && !data_encoding_state ##1 rd_st |=> reg_rdata[3]; endproperty
  a_link: assert property (p_link) else $error("link flag clear");
  property p_realign; sysref_realign ##1 rd_st |=> reg_rdata[2]; endproperty
  a_realign: assert property (p_realign) else $error("realign flag clear");
  property p_phase; nco_sync ##1 rd_st |=> reg_rdata[1]; endproperty
  a_phase: assert property (p_phase) else $error("phase flag clear");
  property p_div; divider_mismatch ##1 rd_st |=> reg_rdata[0]; endproperty
  a_div: assert property (p_div) else $error("divider flag clear");
  property p_sum; rd_sum |=> reg_rdata == {7'h00, $past(alarm_irq)}; endproperty
  a_sum: assert property (p_sum) else $error("summary read wrong");
  property p_pin; 1 |=> status_output_pin == $past(alarm_irq) || status_output_pin == $past(cal_status); endproperty
  a_pin: assert property (p_pin) else $error("pin source wrong");
  property p_rst; disable iff (1'b0) !reset_n |=> !alarm_irq; endproperty
  a_rst: assert property (p_rst) else $error("irq after reset");
endmodule
bind asag_top asag_checker asag_checker_inst (.clock(clock), .reset_n(reset_n), .reg_addr(reg_addr),
  .reg_read(reg_read), .reg_rdata(reg_rdata), .pll_locked(pll_locked), .link_enable(link_enable),
  .data_encoding_state(data_encoding_state), .sysref_realign(sysref_realign), .nco_sync(nco_sync),
  .divider_mismatch(divider_mismatch), .cal_status(cal_status), .status_output_pin(status_output_pin),
  .alarm_irq(alarm_irq));

// [sim/test_alarm_status_aggregator.sv]
// Self-checking bench: random register traffic and alarm conditions against a model.
// Assumes the design sources and asag_defs.svh are compiled first.
`timescale 1ns/10ps
`include "asag_defs.svh"
module test_alarm_status_aggregator;
  logic clock = 0, reset_n = 0, wr = 0, rd = 0, irq, pin, sel = 0, pl = 1;
  logic [11:0] ad = 0;
  logic [7:0] wd = 0, c = 8'h03, rdata, st = 8'h1f, mk = 8'h1f, erd = 0, epin = 0;
  logic [31:0] r;
  int error_cnt = 0, cmp_count = 0, seed = 75, cyc = 0, i;
  asag_top asag_top_inst (.clock(clock), .reset_n(reset_n), .reg_addr(ad), .reg_wdata(wd),
    .reg_write(wr), .reg_read(rd), .reg_rdata(rdata), .pll_locked(c[0]), .link_enable(c[1]),
    .data_encoding_state(c[2]), .sysref_realign(c[3]), .nco_sync(c[4]), .nco_phase_mismatch(c[5]),
    .divider_mismatch(c[6]), .cal_status(c[7]), .status_output_pin(pin), .alarm_irq(irq));
  initial forever #2 clock = ~clock;
  task chk(string n, logic [7:0] e, logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  task end_of_test;
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ----------
  // Model
  // ----------
  always @(posedge clock) begin
    cyc++;
    if (cyc > 6000) begin
      error_cnt++;
      end_of_test;
    end
    erd = 8'h00;
    epin = sel ? (st[4:0] & ~mk[4:0]) != 0 : c[7];
    if (rd && ad == `ASAG_ADDR_SUMMARY) erd = (st[4:0] & ~mk[4:0]) != 0;
    if (rd && ad == `ASAG_ADDR_STATUS) erd = st;
    if (rd && ad == `ASAG_ADDR_MASK) erd = mk;
    if (rd && ad == `ASAG_ADDR_CAL_SEL) erd = {7'h00, sel};
    if (wr && ad == `ASAG_ADDR_STATUS) st = {wd[7:5], st[4:0] & ~wd[4:0]};
    if (wr && ad == `ASAG_ADDR_MASK) mk = wd;
    if (wr && ad == `ASAG_ADDR_CAL_SEL) sel = wd[0];
    st[4:0] |= {!c[0], c[1] & !c[2], c[3], c[4] | c[5] | pl & !c[1], c[6]};
    pl = c[1];
    if (!reset_n) begin
      {st, mk, sel, erd, epin} = {8'h1f, 8'h1f, 1'b0, 8'h00, 8'h00};
    end
  end
  always @(negedge clock) if (cyc > 1) begin
    chk("irq", (st[4:0] & ~mk[4:0]) != 0, irq);
    chk("rdata", erd, rdata);
    chk("pin", epin, pin);
  end
  initial begin
    repeat (12) @(posedge clock);
    reset_n <= 1;
    @(posedge clock);
    {rd, ad} <= {1'b1, `ASAG_ADDR_STATUS};
    @(posedge clock);
    ad <= `ASAG_ADDR_MASK;
    @(posedge clock);
    rd <= 0;
    $display("reset value test done");
    // Conditions stay rare so that clears are seen to stick
    for (i = 0; i < 4000; i++) begin
      @(posedge clock);
      c <= 8'(($random(seed) & $random(seed) & $random(seed) & 8'h7f ^ 8'h07) | ($random(seed) & 8'h80));
      r = $random(seed);
      wr <= r[1:0] == 1;
      rd <= r[1:0] == 2;
      ad <= 12'h02c0 + r[4:2];
      wd <= r[31:24];
    end
    $display("random test done");
    end_of_test;
  end
endmodule
